// ---- src/intc_core.sv ----
// Interrupt status, enable and clear register block with APB access
`timescale 1ns/100ps
module intc_core (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [intc_pkg::ADDR_W-1:0] paddr,
	input wire logic [intc_pkg::DATA_W-1:0] pwdata,
	output logic [intc_pkg::DATA_W-1:0] prdata,
	output logic pready,
	output logic pslverr,
	// Event sources
	input wire intc_pkg::set1_events_t set1_ev,
	input wire logic [intc_pkg::DATA_W-1:0] set2_ev,
	input wire logic [intc_pkg::SET5_EV_W-1:0] set5_ev,
	input wire intc_pkg::pins_t pins,
	input wire logic [intc_pkg::HP_SOURCES:1] hp_sources,
	// CPU side
	output intc_pkg::cpu_req_t cpu_req,
	output logic [intc_pkg::VEC_W-1:0] prio_vector
);
	import intc_pkg::*;

	// ****************************************
	// State
	// ****************************************
	typedef struct packed {
		logic [NUM_SETS-1:0][DATA_W-1:0] status;
		logic [NUM_SETS-1:0][DATA_W-1:0] enable;
		logic [MASK_W-1:0] mask;
		logic gate;
		logic [VEC_W-1:0] vector;
		cpu_req_t req;
		logic [DATA_W-1:0] rdata;
		logic ready;
		logic err;
	} core_state_t;

	core_state_t s_reg;
	core_state_t s_next;

	logic [NUM_SETS-1:0][DATA_W-1:0] set_vec;
	logic [NUM_SETS-1:0][DATA_W-1:0] clr_vec;
	logic [DATA_W-1:0] set1_vec;
	logic [EDGE_PINS-1:0] pin_rise;
	logic [EDGE_PINS-1:0] pin_fall;
	logic hp_request;
	logic [VEC_W-1:0] hp_level;
	logic setup_phase;
	logic write_go;
	logic low_term;

	// ****************************************
	// Address decode
	// ****************************************
	function automatic logic [ADDR_W-1:0] set_addr(input logic [ADDR_W-1:0] base, input int k);
		return ADDR_W'(base + ADDR_W'(k) * WORD_STEP);
	endfunction

	function automatic logic [DATA_W-1:0] read_word(input core_state_t st,
		input logic [ADDR_W-1:0] a);
		logic [DATA_W-1:0] r;
		r = '0;
		for (int k = 0; k < NUM_SETS; k++) begin
			if (a == set_addr(STATUS1_OFF, k)) begin
				r = st.status[k];
			end
			if (a == set_addr(ENABLE1_OFF, k)) begin
				r = st.enable[k];
			end
		end
		if (a == CONTROL6_OFF) begin
			r[MASK_LSB +: MASK_W] = st.mask;
			r[VEC_LSB +: VEC_W] = st.vector;
			r[LOW_BIT] = st.req.low;
			r[HIGH_BIT] = st.req.high;
			r[GATE_BIT] = st.gate;
		end
		return r;
	endfunction

	function automatic logic mapped(input logic [ADDR_W-1:0] a);
		logic m;
		m = (a == CONTROL6_OFF);
		for (int k = 0; k < NUM_SETS; k++) begin
			if (a == set_addr(STATUS1_OFF, k) || a == set_addr(ENABLE1_OFF, k)) begin
				m = 1'b1;
			end
		end
		return m;
	endfunction

	// ****************************************
	// Sources
	// ****************************************
	pin_edge_sync #(
		.W(EDGE_PINS)
	) u_edges (
		.pclk(pclk),
		.presetn(presetn),
		.pins_in(pins),
		.rise(pin_rise),
		.fall(pin_fall)
	);

	prio_encoder #(
		.SRC(HP_SOURCES),
		.VW(VEC_W)
	) u_prio (
		.mask(s_reg.mask),
		.sources(hp_sources),
		.request(hp_request),
		.level(hp_level)
	);

	// Set 1: named module events and the toggle/activity detectors
	always_comb begin
		set1_vec = '0;
		set1_vec[FRAME_END_BIT] = set1_ev.frame_end;
		set1_vec[POLARITY_BIT] = pin_rise[1] | pin_fall[1];
		set1_vec[TDM_HALF_BIT] = set1_ev.tdm_half;
		set1_vec[TDM_END_BIT] = set1_ev.tdm_end;
		set1_vec[TDM_STEP_BIT] = set1_ev.tdm_step;
		set1_vec[HOLD_A_BIT] = set1_ev.hold_a;
		set1_vec[HOLD_B_BIT] = set1_ev.hold_b;
		set1_vec[TDM_WAKE_BIT] = pin_rise[0] | pin_fall[0];
		set1_vec[TDM_ERR_BIT] = set1_ev.tdm_err;
		set1_vec[AUDIO_HALF_BIT] = set1_ev.audio_half;
		set1_vec[AUDIO_END_BIT] = set1_ev.audio_end;
		set1_vec[PHONE_HALF_BIT] = set1_ev.phone_half;
		set1_vec[PHONE_END_BIT] = set1_ev.phone_end;
		set1_vec[AUDIO_STEP_BIT] = set1_ev.audio_step;
		set1_vec[PHONE_STEP_BIT] = set1_ev.phone_step;
		set1_vec[LEFT_CLIP_BIT] = set1_ev.left_clip;
		set1_vec[RIGHT_CLIP_BIT] = set1_ev.right_clip;
		set1_vec[SET1_MISC_LSB +: SET1_MISC_W] = set1_ev.misc;
	end

	// Sets 2 to 5: module events and separate pin edge flags
	assign set_vec[0] = set1_vec;
	assign set_vec[1] = set2_ev & SET2_USED;
	assign set_vec[2] = pin_rise[EDGE_PINS-1 -: MFIO_PINS];
	assign set_vec[3] = pin_fall[EDGE_PINS-1 -: MFIO_PINS];
	assign set_vec[4] = {set5_ev, pin_rise[2 +: IO_PINS], pin_fall[2 +: IO_PINS]};

	// ****************************************
	// APB phases
	// ****************************************
	assign setup_phase = psel && !penable;
	assign write_go = psel && penable && s_reg.ready && pwrite;

	for (genvar k = 0; k < NUM_SETS; k++) begin : g_clr
		assign clr_vec[k] = (write_go && paddr == set_addr(STATUS1_OFF, k)) ? pwdata : '0;
	end

	assign low_term = |(s_reg.status & s_reg.enable);

	// ****************************************
	// Next state
	// ****************************************
	always_comb begin
		s_next = s_reg;
		for (int k = 0; k < NUM_SETS; k++) begin
			// Set beats clear in the same cycle; zero bits of a clear write do nothing
			s_next.status[k] = (s_reg.status[k] & ~clr_vec[k]) | set_vec[k];
			if (write_go && paddr == set_addr(ENABLE1_OFF, k)) begin
				s_next.enable[k] = pwdata;
			end
		end
		if (write_go && paddr == CONTROL6_OFF) begin
			s_next.mask = pwdata[MASK_LSB +: MASK_W];
			s_next.gate = pwdata[GATE_BIT];
		end
		s_next.req.low = s_reg.gate && low_term;
		s_next.req.high = hp_request;
		s_next.req.cop_cond = hp_request;
		s_next.req.irq = hp_request || (s_reg.gate && low_term);
		s_next.vector = hp_level;
		if (setup_phase) begin
			s_next.ready = 1'b1;
			s_next.rdata = read_word(s_reg, paddr);
			s_next.err = !mapped(paddr);
		end else if (psel && penable && s_reg.ready) begin
			s_next.ready = 1'b0;
			s_next.err = 1'b0;
		end
	end

	// Reset holds every status bit cleared and the gate closed
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_reg <= '0;
		end else begin
			s_reg <= s_next;
		end
	end

	assign prdata = s_reg.rdata;
	assign pready = s_reg.ready;
	assign pslverr = s_reg.err;
	assign cpu_req = s_reg.req;
	assign prio_vector = s_reg.vector;

	// ****************************************
	// Checks
	// ****************************************
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	a_clear_takes_effect: assert property (
		(clr_vec[0] != '0 && (clr_vec[0] & set_vec[0]) == '0)
		|=> (s_reg.status[0] & $past(clr_vec[0])) == '0
	) else $error("clear write left a status bit set");

	a_status_sticky: assert property (
		(s_reg.status[1] & ~clr_vec[1]) != '0
		|=> (s_reg.status[1] & $past(s_reg.status[1] & ~clr_vec[1]))
			== $past(s_reg.status[1] & ~clr_vec[1])
	) else $error("status bit dropped without a clear");

	a_set_wins: assert property (
		set_vec[0] != '0 |=> (s_reg.status[0] & $past(set_vec[0])) == $past(set_vec[0])
	) else $error("event did not set its status bit");

	a_low_gated: assert property (
		!s_reg.gate |=> !s_reg.req.low
	) else $error("low request raised with gate closed");

	a_low_follows: assert property (
		(s_reg.gate && low_term) |=> s_reg.req.low
	) else $error("low request missing for enabled status");

	a_high_source: assert property (
		(s_reg.mask[HP_SOURCES] && hp_sources[HP_SOURCES])
		|=> s_reg.req.high && s_reg.vector == VEC_W'(HP_SOURCES)
	) else $error("top priority source not reported");

	a_irq_either: assert property (
		s_reg.req.irq == (s_reg.req.high || s_reg.req.low)
	) else $error("overall request disagrees with high and low");

	a_cop_mirror: assert property (
		s_reg.req.cop_cond == s_reg.req.high
	) else $error("coprocessor condition differs from high request");

	a_pin_rise_seen: assert property (
		$rose(pins.mfio[0]) |-> ##3 s_reg.status[2][0]
	) else $error("pin rise not captured in three cycles");

	a_pin_rise_once: assert property (
		pin_rise[EDGE_PINS-MFIO_PINS] |=> !pin_rise[EDGE_PINS-MFIO_PINS]
	) else $error("pin rise pulse lasted more than one cycle");

	a_edges_exclusive: assert property (
		(pin_rise & pin_fall) == '0
	) else $error("rise and fall flagged together on one pin");

	a_read_snapshot: assert property (
		setup_phase && paddr == STATUS1_OFF
		|=> prdata == $past(s_reg.status[0])
	) else $error("status read returned wrong data");

	a_ready_single: assert property (
		s_reg.ready |=> !s_reg.ready
	) else $error("ready held for more than one cycle");

	a_enable_write: assert property (
		write_go && paddr == ENABLE1_OFF
		|=> s_reg.enable[0] == $past(pwdata)
	) else $error("enable write did not land");

	a_mask_write: assert property (
		write_go && paddr == CONTROL6_OFF
		|=> s_reg.mask == $past(pwdata[MASK_LSB +: MASK_W]) && s_reg.gate == $past(pwdata[GATE_BIT])
	) else $error("mask or gate write did not land");

	a_enable_blocks: assert property (
		(s_reg.status & s_reg.enable) == '0
		|=> !s_reg.req.low
	) else $error("low request without an enabled status");

	a_gate_closed_irq: assert property (
		!s_reg.gate && !hp_request
		|=> !s_reg.req.irq
	) else $error("request raised with gate closed and no high source");

	a_vector_zero: assert property (
		(s_reg.mask & {hp_sources, 1'b0}) == '0 |=> s_reg.vector == '0
	) else $error("vector nonzero with nothing pending");

	c_clear_write: cover property (write_go && clr_vec[0] != '0);
	c_low_request: cover property (s_reg.req.low);
	c_high_request: cover property (s_reg.req.high && s_reg.vector != '0);
	c_set_and_clear: cover property ((set_vec[0] & clr_vec[0]) != '0);
	c_pin_rise: cover property (pin_rise != '0);

endmodule

// ---- src/intc_pkg.sv ----
// Shared constants, register map and carrier types of the interrupt block
package intc_pkg;

	// ****************************************
	// Sizes
	// ****************************************
	localparam int DATA_W = 32;
	localparam int ADDR_W = 12;
	localparam int NUM_SETS = 5;
	localparam int HP_SOURCES = 15;
	localparam int MASK_W = 16;
	localparam int VEC_W = 4;
	localparam int MFIO_PINS = 32;
	localparam int IO_PINS = 7;
	localparam int EDGE_PINS = MFIO_PINS + IO_PINS + 2;
	localparam int SET5_EV_W = 18;
	localparam int SET1_MISC_W = 10;

	// ****************************************
	// Register offsets (byte addresses)
	// ****************************************
	localparam logic [ADDR_W-1:0] STATUS1_OFF = 12'h100;
	localparam logic [ADDR_W-1:0] ENABLE1_OFF = 12'h120;
	localparam logic [ADDR_W-1:0] CONTROL6_OFF = 12'h134;
	localparam logic [ADDR_W-1:0] WORD_STEP = 12'h004;

	// ****************************************
	// Control register 6 fields
	// ****************************************
	localparam int MASK_LSB = 0;
	localparam int VEC_LSB = 16;
	localparam int LOW_BIT = 20;
	localparam int HIGH_BIT = 21;
	localparam int GATE_BIT = 31;

	// ****************************************
	// Status set 1 and set 5 bit positions
	// ****************************************
	localparam int FRAME_END_BIT = 31;
	localparam int POLARITY_BIT = 30;
	localparam int TDM_HALF_BIT = 29;
	localparam int TDM_END_BIT = 28;
	localparam int TDM_STEP_BIT = 27;
	localparam int HOLD_A_BIT = 26;
	localparam int HOLD_B_BIT = 25;
	localparam int TDM_WAKE_BIT = 24;
	localparam int TDM_ERR_BIT = 23;
	localparam int AUDIO_HALF_BIT = 22;
	localparam int AUDIO_END_BIT = 21;
	localparam int PHONE_HALF_BIT = 20;
	localparam int PHONE_END_BIT = 19;
	localparam int AUDIO_STEP_BIT = 18;
	localparam int PHONE_STEP_BIT = 17;
	localparam int LEFT_CLIP_BIT = 16;
	localparam int RIGHT_CLIP_BIT = 15;
	localparam int SET1_MISC_LSB = 5;
	localparam int SET5_EV_LSB = 14;
	localparam int SET5_POS_LSB = 7;
	localparam int SET5_NEG_LSB = 0;

	// Implemented bits of set 2; the rest read as zero
	localparam logic [DATA_W-1:0] SET2_USED = 32'hFFFFF000;

	// ****************************************
	// Carrier types
	// ****************************************
	typedef struct packed {
		logic frame_end;
		logic tdm_half;
		logic tdm_end;
		logic tdm_step;
		logic hold_a;
		logic hold_b;
		logic tdm_err;
		logic audio_half;
		logic audio_end;
		logic phone_half;
		logic phone_end;
		logic audio_step;
		logic phone_step;
		logic left_clip;
		logic right_clip;
		logic [SET1_MISC_W-1:0] misc;
	} set1_events_t;

	typedef struct packed {
		logic [MFIO_PINS-1:0] mfio;
		logic [IO_PINS-1:0] io;
		logic polarity;
		logic tdm_link_clock;
	} pins_t;

	typedef struct packed {
		logic irq;
		logic high;
		logic low;
		logic cop_cond;
	} cpu_req_t;

endpackage

// ---- src/pin_edge_sync.sv ----
// Two-flop synchroniser with rising and falling edge detection per pin
`timescale 1ns/100ps
module pin_edge_sync #(
	parameter int W = 8
) (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Pins
	input wire logic [W-1:0] pins_in,
	// Edge pulses
	output logic [W-1:0] rise,
	output logic [W-1:0] fall
);
	typedef struct packed {
		logic [W-1:0] meta;
		logic [W-1:0] stable;
		logic [W-1:0] prev;
	} edge_state_t;

	edge_state_t s_reg;
	edge_state_t s_next;

	// First stage feeds only the second stage
	always_comb begin
		s_next = s_reg;
		s_next.meta = pins_in;
		s_next.stable = s_reg.meta;
		s_next.prev = s_reg.stable;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_reg <= '0;
		end else begin
			s_reg <= s_next;
		end
	end

	// One pulse per settled transition
	assign rise = s_reg.stable & ~s_reg.prev;
	assign fall = ~s_reg.stable & s_reg.prev;

endmodule

// ---- src/prio_encoder.sv ----
// Priority mask gating and highest-level encoder
`timescale 1ns/100ps
module prio_encoder #(
	parameter int SRC = 15,
	parameter int VW = 4
) (
	// Mask and sources, bit 0 of the mask has no source
	input wire logic [SRC:0] mask,
	input wire logic [SRC:1] sources,
	// Results
	output logic request,
	output logic [VW-1:0] level
);
	logic [SRC:0] gated;

	function automatic logic [VW-1:0] highest(input logic [SRC:0] v);
		logic [VW-1:0] r;
		r = '0;
		for (int i = 1; i <= SRC; i++) begin
			if (v[i]) begin
				r = VW'(i);
			end
		end
		return r;
	endfunction

	assign gated = mask & {sources, 1'b0};
	assign request = |gated;
	assign level = highest(gated);

endmodule

// ---- test/cpu_model.sv ----
// CPU side model: master on the register port
`timescale 1ns/100ps
module cpu_model (
	// Clock
	input wire logic pclk,
	// APB master
	output logic psel,
	output logic penable,
	output logic pwrite,
	output logic [intc_pkg::ADDR_W-1:0] paddr,
	output logic [intc_pkg::DATA_W-1:0] pwdata,
	input wire logic [intc_pkg::DATA_W-1:0] prdata,
	input wire logic pready,
	input wire logic pslverr
);
	import intc_pkg::*;
	initial begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = '0;
		pwdata = '0;
	end
	// Request held until pready is seen at a rising edge
	task automatic xfer(input logic wr, input logic [ADDR_W-1:0] a,
		input logic [DATA_W-1:0] d, output logic [DATA_W-1:0] q, output logic err);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		q = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		// Released lines do not keep the last value
		paddr <= ~a;
		pwdata <= ~d;
	endtask
endmodule

// ---- test/interrupt_status_enable_clear_bench.sv ----
// Self-checking bench of the interrupt block
`timescale 1ns/100ps
module interrupt_status_enable_clear_bench;
	import intc_pkg::*;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic [ADDR_W-1:0] paddr;
	logic [DATA_W-1:0] pwdata, prdata, set2_ev;
	set1_events_t set1_ev;
	logic [SET5_EV_W-1:0] set5_ev;
	pins_t pins;
	logic [HP_SOURCES:1] hp_sources;
	cpu_req_t cpu_req;
	logic [VEC_W-1:0] prio_vector;
	int error_cnt, comparisons;

	intc_core dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .set1_ev(set1_ev), .set2_ev(set2_ev), .set5_ev(set5_ev),
		.pins(pins), .hp_sources(hp_sources), .cpu_req(cpu_req), .prio_vector(prio_vector));
	cpu_model cpu (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

	initial pclk = 1'b0;
	always #10 pclk = ~pclk;

	// ****************************************
	// Helpers
	// ****************************************
	task automatic conclude();
		$display("Comparisons %0d, errors %0d", comparisons, error_cnt);
		if (error_cnt == 0 && comparisons > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	task automatic fail(input string m);
		error_cnt++;
		$display("CHECK FAILED at %0t: %s", $time, m);
	endtask
	task automatic chk(input logic [DATA_W-1:0] got, exp, input string m);
		comparisons++;
		if (got !== exp) begin
			fail($sformatf("%s got %h expected %h", m, got, exp));
		end
	endtask
	task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
		logic [DATA_W-1:0] q;
		logic e;
		cpu.xfer(1'b1, a, d, q, e);
		if (e !== 1'b0) begin
			fail("write answered with error");
		end
	endtask
	task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp, input string m);
		logic [DATA_W-1:0] q;
		logic e;
		cpu.xfer(1'b0, a, '0, q, e);
		chk(q, exp, m);
	endtask
	task automatic req(input cpu_req_t exp, input logic [VEC_W-1:0] vec, input string m);
		repeat (2) @(posedge pclk);
		@(negedge pclk);
		chk({24'h0, cpu_req, prio_vector}, {24'h0, exp, vec}, m);
	endtask
	task automatic pulse(input set1_events_t a, input logic [DATA_W-1:0] b,
		input logic [SET5_EV_W-1:0] c);
		@(posedge pclk);
		set1_ev <= a;
		set2_ev <= b;
		set5_ev <= c;
		@(posedge pclk);
		set1_ev <= '0;
		set2_ev <= '0;
		set5_ev <= '0;
	endtask

	// ****************************************
	// Scenarios
	// ****************************************
	task automatic t_reset();
		pulse('1, '0, '0);
		@(posedge pclk);
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		rd(STATUS1_OFF, 32'h0, "status after reset");
		rd(CONTROL6_OFF, 32'h0, "control after reset");
		rd(ENABLE1_OFF, 32'h0, "enable after reset");
		req(4'h0, 4'h0, "requests after reset");
	endtask
	task automatic t_events();
		pulse('1, '1, '1);
		rd(STATUS1_OFF, 32'hBEFFFFE0, "set 1 events");
		rd(STATUS1_OFF + 12'h004, SET2_USED, "set 2 events");
		rd(STATUS1_OFF + 12'h010, 32'hFFFFC000, "set 5 events");
		wr(STATUS1_OFF, 32'h0);
		rd(STATUS1_OFF, 32'hBEFFFFE0, "zero clear keeps status");
		wr(STATUS1_OFF, 32'h80000000);
		rd(STATUS1_OFF, 32'h3EFFFFE0, "single bit clear");
		wr(STATUS1_OFF, '1);
		wr(STATUS1_OFF + 12'h004, '1);
		wr(STATUS1_OFF + 12'h010, '1);
		rd(STATUS1_OFF, 32'h0, "all cleared");
	endtask
	task automatic t_pins();
		@(posedge pclk);
		pins <= '1;
		repeat (5) @(posedge pclk);
		rd(STATUS1_OFF + 12'h008, '1, "rising pins");
		rd(STATUS1_OFF + 12'h00C, 32'h0, "no falling flag");
		rd(STATUS1_OFF + 12'h010, 32'h00003F80, "io rising");
		rd(STATUS1_OFF, 32'h41000000, "polarity and link clock");
		wr(STATUS1_OFF, '1);
		wr(STATUS1_OFF + 12'h008, '1);
		wr(STATUS1_OFF + 12'h010, '1);
		repeat (5) @(posedge pclk);
		rd(STATUS1_OFF + 12'h008, 32'h0, "one set per edge");
		@(posedge pclk);
		pins <= '0;
		repeat (5) @(posedge pclk);
		rd(STATUS1_OFF + 12'h00C, '1, "falling pins");
		rd(STATUS1_OFF + 12'h010, 32'h0000007F, "io falling");
		rd(STATUS1_OFF, 32'h41000000, "both edges flag");
		wr(STATUS1_OFF, '1);
		wr(STATUS1_OFF + 12'h00C, '1);
		wr(STATUS1_OFF + 12'h010, '1);
	endtask
	task automatic t_low();
		set1_events_t ev;
		ev = '0;
		ev.frame_end = 1'b1;
		pulse(ev, '0, '0);
		wr(ENABLE1_OFF, 32'h80000000);
		rd(ENABLE1_OFF, 32'h80000000, "enable read back");
		wr(ENABLE1_OFF + 12'h010, 32'hFFFFC000);
		rd(ENABLE1_OFF + 12'h010, 32'hFFFFC000, "enable 5 read back");
		wr(ENABLE1_OFF + 12'h010, 32'h0);
		req(4'h0, 4'h0, "gate closed");
		wr(CONTROL6_OFF, 32'h80000000);
		req(4'b1010, 4'h0, "low request");
		rd(CONTROL6_OFF, 32'h80100000, "low readback");
		wr(ENABLE1_OFF, 32'h0);
		req(4'h0, 4'h0, "source disabled");
		wr(ENABLE1_OFF, 32'h80000000);
		req(4'b1010, 4'h0, "source enabled again");
		wr(STATUS1_OFF, 32'h80000000);
		req(4'h0, 4'h0, "cleared status");
		wr(CONTROL6_OFF, 32'h0);
		wr(ENABLE1_OFF, 32'h0);
	endtask
	task automatic t_high();
		logic [HP_SOURCES:1] v;
		wr(CONTROL6_OFF, 32'h0000FFFF);
		for (int i = 1; i <= HP_SOURCES; i++) begin
			v = '0;
			v[i] = 1'b1;
			@(posedge pclk);
			hp_sources <= v;
			req(4'b1101, 4'(i), "single source level");
		end
		@(posedge pclk);
		hp_sources <= '1;
		wr(CONTROL6_OFF, 32'h00007FFF);
		req(4'b1101, 4'hE, "top level masked");
		rd(CONTROL6_OFF, 32'h002E7FFF, "high readback");
		wr(CONTROL6_OFF, 32'h001F0001);
		req(4'h0, 4'h0, "mask bit 0 gates nothing");
		rd(CONTROL6_OFF, 32'h00000001, "readonly fields kept");
		@(posedge pclk);
		hp_sources <= '0;
		wr(CONTROL6_OFF, 32'h0);
	endtask
	task automatic t_unmapped();
		logic [DATA_W-1:0] q;
		logic e;
		cpu.xfer(1'b1, 12'h114, '1, q, e);
		chk({31'h0, e}, 32'h1, "unmapped write error");
		cpu.xfer(1'b0, 12'h114, '0, q, e);
		chk({31'h0, e}, 32'h1, "unmapped read error");
		chk(q, 32'h0, "unmapped read data");
	endtask

	// ****************************************
	// Main sequence and watchdog
	// ****************************************
	initial begin
		error_cnt = 0;
		comparisons = 0;
		presetn = 1'b0;
		set1_ev = '0;
		set2_ev = '0;
		set5_ev = '0;
		pins = '0;
		hp_sources = '0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		t_reset();
		t_events();
		t_pins();
		t_low();
		t_high();
		t_unmapped();
		conclude();
	end
	initial begin
		#400us;
		fail("watchdog expired");
		conclude();
	end
endmodule
